// file: rtl/ecn_canceller_ctrl.sv
// Per-canceller decode of control registers into registered actions
`timescale 1ns/100ps
module ecn_canceller_ctrl (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Register contents
   input wire logic [7:0] procCtrl,
   input wire logic [7:0] convCtrl,
   input wire logic [7:0] noiseScale,
   input wire logic [7:0] noiseCtrl,
   // Canceller events
   input wire ecn_pkg::ecn_event_t events,
   // Decoded controls and actions
   output ecn_pkg::ecn_ctrl_t ctrl_ff,
   output ecn_pkg::ecn_action_t action_ff
);

   ecn_pkg::ecn_ctrl_t nxt_ctrl;
   ecn_pkg::ecn_action_t nxt_action;

   always_comb begin
      nxt_ctrl.advancedSel = procCtrl[ecn_pkg::PC_ADV_SEL];
      // Advanced-only features read as unsupported with the original processor
      nxt_ctrl.rejectEcho = procCtrl[ecn_pkg::PC_REJ_ECHO] & nxt_ctrl.advancedSel;
      nxt_ctrl.rejectDoubletalk = procCtrl[ecn_pkg::PC_REJ_DT] & nxt_ctrl.advancedSel;
      nxt_ctrl.rampSchemeSel = procCtrl[ecn_pkg::PC_RAMP_SEL] & nxt_ctrl.advancedSel;
      nxt_ctrl.instabilityDetectEn = procCtrl[ecn_pkg::PC_INSTAB];
      nxt_ctrl.pathChangeDetectEn = procCtrl[ecn_pkg::PC_PATH_DET];
      // Clear option only meaningful with detection on
      nxt_ctrl.estimateClearOnChange = procCtrl[ecn_pkg::PC_EST_CLR]
         & procCtrl[ecn_pkg::PC_PATH_DET];
      nxt_ctrl.convergenceSuppress = convCtrl[ecn_pkg::CC_SUP_LSB +: 3];
      nxt_ctrl.slowShift = convCtrl[ecn_pkg::CC_SLOW_LSB +: 3];
      nxt_ctrl.noiseRampRate = noiseCtrl[3:0];
      nxt_ctrl.comfortNoiseScale = noiseScale;
   end

   always_comb begin
      nxt_action.instabilityActive = nxt_ctrl.instabilityDetectEn & events.instability;
      // Any detected change restarts fast convergence; clearing is optional
      nxt_action.fastConverge = nxt_ctrl.pathChangeDetectEn & events.pathChange;
      nxt_action.clearEstimate = nxt_action.fastConverge & nxt_ctrl.estimateClearOnChange;
      // Adaptation step divided by 2^N; N = 0 keeps normal speed
      nxt_action.adaptShift = 8'h01 << nxt_ctrl.slowShift;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctrl_ff <= '0;
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         action_ff <= '0;
      end else begin
         action_ff <= nxt_action;
      end
   end

endmodule

// file: rtl/ecn_nlp_regs.sv
// Top: AXI4-Lite control bank for one canceller pair
//
// What this block does
// - Echo-rejection bit steers noise estimator, advanced only.
// - Path-clear set: discard estimate, fast convergence.
// - Path-clear low: keep estimate, fast convergence.
// - Path-clear ignored when detector disabled.
// - Path-detect bit enables the path change detector.
// - Processor-select high picks advanced processor, default 1.
// - Double-talk rejection bit, default 1, advanced only.
// - Ramp-scheme bit selects ramping, default 1.
// - Ramp rate defaults 5 hex, original C; reset loads 5 for either processor and RAMP_RATE_ORIGINAL is never applied.
// - Noise scale value scales comfort noise level.
// - Noise scale powers up at 16 hex.
// - Processor control at offsets 08 and 28.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps
module ecn_nlp_regs (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // AXI4-Lite write address
   input wire logic [ecn_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [ecn_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Canceller events
   input wire ecn_pkg::ecn_event_t eventsFirst,
   input wire ecn_pkg::ecn_event_t eventsSecond,
   // Canceller controls and actions
   output ecn_pkg::ecn_ctrl_t ctrlFirst_ff,
   output ecn_pkg::ecn_ctrl_t ctrlSecond_ff,
   output ecn_pkg::ecn_action_t actionFirst_ff,
   output ecn_pkg::ecn_action_t actionSecond_ff
);

   // ****************************************
   // Register storage
   // ****************************************
   // Index 0 is the first canceller, 1 the second
   logic [7:0] procCtrl_ff [2];
   logic [7:0] convCtrl_ff [2];
   logic [7:0] noiseScale_ff [2];
   logic [7:0] noiseCtrl_ff [2];

   logic [ecn_pkg::ADDR_W-1:0] awAddr_ff;
   logic awHave_ff;
   logic [31:0] wData_ff;
   logic [3:0] wStrb_ff;
   logic wHave_ff;

   // Register id: bit 2 = canceller, bits 1:0 = register; valid flag bit 3
   function automatic logic [3:0] decode(input logic [ecn_pkg::ADDR_W-1:0] addr);
      logic [7:0] idx;
      idx = addr[ecn_pkg::ADDR_W-1:2];
      decode = 4'h0;
      if (addr[1:0] == 2'b00) begin
         unique case (idx)
            ecn_pkg::IDX_CA_PROC_CTRL: decode = 4'h8;
            ecn_pkg::IDX_CA_CONV_CTRL: decode = 4'h9;
            ecn_pkg::IDX_CA_NOISE_SCALE: decode = 4'hA;
            ecn_pkg::IDX_CA_NOISE_CTRL: decode = 4'hB;
            ecn_pkg::IDX_CB_PROC_CTRL: decode = 4'hC;
            ecn_pkg::IDX_CB_CONV_CTRL: decode = 4'hD;
            ecn_pkg::IDX_CB_NOISE_SCALE: decode = 4'hE;
            ecn_pkg::IDX_CB_NOISE_CTRL: decode = 4'hF;
            default: decode = 4'h0;
         endcase
      end
   endfunction

   // ****************************************
   // Write channel
   // ****************************************
   logic doWrite;
   logic [3:0] wrSel;
   assign doWrite = awHave_ff && wHave_ff && !s_axi_bvalid;
   assign wrSel = decode(awAddr_ff);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         awHave_ff <= 1'b0;
         awAddr_ff <= '0;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= 1'b0;
         if (doWrite) begin
            awHave_ff <= 1'b0;
         end else if (s_axi_awvalid && !awHave_ff && !s_axi_awready) begin
            awHave_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
            s_axi_awready <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wHave_ff <= 1'b0;
         wData_ff <= '0;
         wStrb_ff <= '0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= 1'b0;
         if (doWrite) begin
            wHave_ff <= 1'b0;
         end else if (s_axi_wvalid && !wHave_ff && !s_axi_wready) begin
            wHave_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ecn_pkg::RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrSel[3] ? ecn_pkg::RESP_OKAY : ecn_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Only byte lane 0 carries register data; other lanes are ignored
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 2; i++) begin
            procCtrl_ff[i] <= ecn_pkg::RST_PROC_CTRL;
            convCtrl_ff[i] <= ecn_pkg::RST_CONV_CTRL;
            noiseScale_ff[i] <= ecn_pkg::RST_NOISE_SCALE;
            noiseCtrl_ff[i] <= ecn_pkg::RST_NOISE_CTRL;
         end
      end else if (doWrite && wrSel[3] && wStrb_ff[0]) begin
         // Fields stored as written; reserved-bit values are software's duty
         unique case (wrSel[1:0])
            2'd0: procCtrl_ff[wrSel[2]] <= wData_ff[7:0];
            2'd1: convCtrl_ff[wrSel[2]] <= wData_ff[7:0];
            2'd2: noiseScale_ff[wrSel[2]] <= wData_ff[7:0];
            2'd3: noiseCtrl_ff[wrSel[2]] <= wData_ff[7:0];
         endcase
      end
   end

   // ****************************************
   // Read channel
   // ****************************************
   logic [3:0] rdSel;
   logic [7:0] rdByte;
   assign rdSel = decode(s_axi_araddr);

   always_comb begin
      unique case (rdSel[1:0])
         2'd0: rdByte = procCtrl_ff[rdSel[2]];
         2'd1: rdByte = convCtrl_ff[rdSel[2]];
         2'd2: rdByte = noiseScale_ff[rdSel[2]];
         2'd3: rdByte = noiseCtrl_ff[rdSel[2]];
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= ecn_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_rvalid) begin
            if (s_axi_rready) begin
               s_axi_rvalid <= 1'b0;
            end
         end else if (s_axi_arready && s_axi_arvalid) begin
            // Address handshake completes at this edge; read data may only follow it
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdSel[3] ? {24'h00_0000, rdByte} : 32'h0000_0000;
            s_axi_rresp <= rdSel[3] ? ecn_pkg::RESP_OKAY : ecn_pkg::RESP_SLVERR;
         end else if (s_axi_arvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ****************************************
   // Per-canceller decode
   // ****************************************
   ecn_canceller_ctrl uFirst (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .procCtrl(procCtrl_ff[0]),
      .convCtrl(convCtrl_ff[0]),
      .noiseScale(noiseScale_ff[0]),
      .noiseCtrl(noiseCtrl_ff[0]),
      .events(eventsFirst),
      .ctrl_ff(ctrlFirst_ff),
      .action_ff(actionFirst_ff)
   );

   ecn_canceller_ctrl uSecond (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .procCtrl(procCtrl_ff[1]),
      .convCtrl(convCtrl_ff[1]),
      .noiseScale(noiseScale_ff[1]),
      .noiseCtrl(noiseCtrl_ff[1]),
      .events(eventsSecond),
      .ctrl_ff(ctrlSecond_ff),
      .action_ff(actionSecond_ff)
   );

endmodule

// file: rtl/ecn_pkg.sv
// Package: register map, field layout and reset values of the canceller control bank
package ecn_pkg;

   // ****************************************
   // Register indices (byte address = 4 * index)
   // ****************************************
   localparam logic [7:0] IDX_CA_PROC_CTRL = 8'h08;
   localparam logic [7:0] IDX_CA_CONV_CTRL = 8'h09;
   localparam logic [7:0] IDX_CA_NOISE_SCALE = 8'h0A;
   localparam logic [7:0] IDX_CA_NOISE_CTRL = 8'h0B;
   localparam logic [7:0] IDX_CB_PROC_CTRL = 8'h28;
   localparam logic [7:0] IDX_CB_CONV_CTRL = 8'h29;
   localparam logic [7:0] IDX_CB_NOISE_SCALE = 8'h2A;
   localparam logic [7:0] IDX_CB_NOISE_CTRL = 8'h2B;
   localparam int ADDR_W = 10;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] RST_PROC_CTRL = 8'hFB;
   localparam logic [7:0] RST_CONV_CTRL = 8'h54;
   localparam logic [7:0] RST_NOISE_SCALE = 8'h16;
   localparam logic [7:0] RST_NOISE_CTRL = 8'h45;
   localparam logic [3:0] RAMP_RATE_ADVANCED = 4'h5;
   localparam logic [3:0] RAMP_RATE_ORIGINAL = 4'hC;

   // ****************************************
   // Processor control field positions
   // ****************************************
   localparam int PC_ADV_SEL = 0;
   localparam int PC_PATH_DET = 1;
   localparam int PC_EST_CLR = 2;
   localparam int PC_RESERVED = 3;
   localparam int PC_INSTAB = 4;
   localparam int PC_REJ_ECHO = 5;
   localparam int PC_RAMP_SEL = 6;
   localparam int PC_REJ_DT = 7;
   // Convergence control fields
   localparam int CC_SLOW_LSB = 0;
   localparam int CC_SUP_LSB = 4;

   // ****************************************
   // AXI response codes
   // ****************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Decoded per-canceller controls
   typedef struct packed {
      logic advancedSel;
      logic rejectEcho;
      logic rejectDoubletalk;
      logic rampSchemeSel;
      logic instabilityDetectEn;
      logic pathChangeDetectEn;
      logic estimateClearOnChange;
      logic [2:0] convergenceSuppress;
      logic [2:0] slowShift;
      logic [3:0] noiseRampRate;
      logic [7:0] comfortNoiseScale;
   } ecn_ctrl_t;

   // Canceller status inputs
   typedef struct packed {
      logic pathChange;
      logic instability;
   } ecn_event_t;

   // Canceller actions derived from controls and events
   typedef struct packed {
      logic clearEstimate;
      logic fastConverge;
      logic instabilityActive;
      logic [7:0] adaptShift;
   } ecn_action_t;

endpackage

// file: tb/ecn_nlp_regs_checker.sv
// Checker: bus handshake and decode relations of the control bank
`timescale 1ns/100ps
module ecn_nlp_regs_checker (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Register bus
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // Canceller side
   input wire ecn_pkg::ecn_event_t eventsFirst,
   input wire ecn_pkg::ecn_event_t eventsSecond,
   input wire ecn_pkg::ecn_ctrl_t ctrlFirst_ff,
   input wire ecn_pkg::ecn_ctrl_t ctrlSecond_ff,
   input wire ecn_pkg::ecn_action_t actionFirst_ff,
   input wire ecn_pkg::ecn_action_t actionSecond_ff
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Stable decode means the action saw the registers that ctrl shows now
   property p_instab;
      $past(resetn) && $stable(ctrlFirst_ff) |-> actionFirst_ff.instabilityActive ==
         ($past(eventsFirst.instability) && ctrlFirst_ff.instabilityDetectEn);
   endproperty
   a_instab: assert property (p_instab) else $error("instability action wrong");
   property p_fast;
      $past(resetn) && $stable(ctrlSecond_ff) |-> actionSecond_ff.fastConverge ==
         ($past(eventsSecond.pathChange) && ctrlSecond_ff.pathChangeDetectEn);
   endproperty
   a_fast: assert property (p_fast) else $error("fast convergence wrong");
   property p_clear;
      $past(resetn) && $stable(ctrlFirst_ff) |-> actionFirst_ff.clearEstimate ==
         ($past(eventsFirst.pathChange) && ctrlFirst_ff.estimateClearOnChange);
   endproperty
   a_clear: assert property (p_clear) else $error("estimate clear wrong");
   property p_shift;
      $past(resetn) && $stable(ctrlFirst_ff) |->
         actionFirst_ff.adaptShift == (8'h01 << ctrlFirst_ff.slowShift);
   endproperty
   a_shift: assert property (p_shift) else $error("adaptation shift wrong");
   property p_orig;
      !ctrlFirst_ff.advancedSel |-> !(ctrlFirst_ff.rejectEcho ||
         ctrlFirst_ff.rejectDoubletalk || ctrlFirst_ff.rampSchemeSel);
   endproperty
   a_orig: assert property (p_orig) else $error("advanced-only bit active");
   property p_mask;
      !ctrlSecond_ff.pathChangeDetectEn |-> !ctrlSecond_ff.estimateClearOnChange;
   endproperty
   a_mask: assert property (p_mask) else $error("path clear not masked");
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_rans;
      s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_arready && !s_axi_rvalid
         ##1 s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rans: assert property (p_rans) else $error("read not answered");
   c_clear: cover property (actionFirst_ff.clearEstimate);
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_arvalid && s_axi_arready);
endmodule

bind ecn_nlp_regs ecn_nlp_regs_checker chk_u (.clk_sys, .resetn, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .eventsFirst,
   .eventsSecond, .ctrlFirst_ff, .ctrlSecond_ff, .actionFirst_ff, .actionSecond_ff);

// file: tb/test_ecn_nlp_regs.sv
// Testbench: register access and decode of the canceller control bank
`timescale 1ns/100ps
module test_ecn_nlp_regs;
   logic clk_sys = 1'b0;
   logic resetn;
   logic [9:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   ecn_pkg::ecn_event_t eventsFirst, eventsSecond;
   ecn_pkg::ecn_ctrl_t ctrlFirst_ff, ctrlSecond_ff;
   ecn_pkg::ecn_action_t actionFirst_ff, actionSecond_ff;
   int nMismatch = 0;
   int checksDone = 0;
   int seed = 20225;
   logic [7:0] mirror [8];

   always #50 clk_sys = ~clk_sys;

   ecn_nlp_regs dut_u (.clk_sys, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .eventsFirst, .eventsSecond, .ctrlFirst_ff, .ctrlSecond_ff,
      .actionFirst_ff, .actionSecond_ff);

   // ****
   // Helpers
   // ****
   function automatic logic [9:0] adr(input int i);
      return {(i < 4 ? 8'h08 : 8'h24) + 8'(i), 2'b00};
   endfunction
   function automatic logic [7:0] rstVal(input int i);
      return i % 4 == 0 ? 8'hFB : i % 4 == 1 ? 8'h54 : i % 4 == 2 ? 8'h16 : 8'h45;
   endfunction
   // Random writes still keep the reserved bits at their required levels
   function automatic logic [7:0] legal(input int i, input logic [7:0] d);
      return i % 4 == 0 ? d | 8'h08 : i % 4 == 1 ? d & 8'h77 : d;
   endfunction
   function automatic logic [3:0] advBits(input ecn_pkg::ecn_ctrl_t c);
      return {c.advancedSel, c.rejectEcho, c.rejectDoubletalk, c.rampSchemeSel};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         nMismatch++;
      end
   endtask
   // Late bready makes the slave hold its response for a cycle
   task automatic axw(input logic [9:0] a, input logic [7:0] d, input logic [3:0] s,
      input logic [1:0] er);
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b1;
      @(posedge clk_sys);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
   endtask
   task automatic axr(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, ed);
      chk(s_axi_rresp, er);
   endtask
   task automatic testDone;
      $display("checks %0d mismatches %0d", checksDone, nMismatch);
      if (nMismatch == 0 && checksDone > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ****
   // Sequence
   // ****
   initial begin
      int r;
      int i;
      logic [7:0] d;
      resetn = 1'b0;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready, eventsFirst, eventsSecond} = '0;
      repeat (12) @(posedge clk_sys);
      resetn <= 1'b1;
      for (i = 0; i < 8; i++) begin
         mirror[i] = rstVal(i);
         axr(adr(i), rstVal(i), 2'h0);
      end
      chk(ctrlFirst_ff.noiseRampRate, 4'h5);
      chk(advBits(ctrlFirst_ff), 4'hF);
      axw(10'h3FC, 8'h5A, 4'hF, 2'h2);
      axr(10'h3FC, 32'h0000_0000, 2'h2);
      for (int k = 0; k < 24; k++) begin
         r = $random(seed);
         i = r[2:0];
         d = legal(i, r[15:8]);
         mirror[i] = d;
         axw(adr(i), d, 4'hF, 2'h0);
      end
      axw(adr(2), 8'hC3, 4'h0, 2'h0);
      for (i = 0; i < 8; i++)
         axr(adr(i), mirror[i], 2'h0);
      for (int n = 0; n < 8; n++) begin
         axw(adr(1), {4'h5, 1'b0, n[2:0]}, 4'hF, 2'h0);
         repeat (3) @(posedge clk_sys);
         chk(actionFirst_ff.adaptShift, 8'h01 << n);
         chk(ctrlFirst_ff.convergenceSuppress, 3'h5);
      end
      for (int m = 0; m < 8; m++) begin
         d = 8'hE9 | {3'h0, m[2], 1'b0, m[1], m[0], 1'b0};
         axw(adr(0), d, 4'hF, 2'h0);
         axw(adr(4), d, 4'hF, 2'h0);
         repeat (2) @(posedge clk_sys);
         eventsFirst <= 2'b11;
         eventsSecond <= 2'b11;
         repeat (3) @(posedge clk_sys);
         chk(actionFirst_ff[10:8], {m[0] & m[1], m[0], m[2]});
         chk(actionSecond_ff[10:8], {m[0] & m[1], m[0], m[2]});
         eventsFirst <= 2'b00;
         eventsSecond <= 2'b00;
         repeat (3) @(posedge clk_sys);
         chk(actionFirst_ff[10:8], 3'h0);
         chk(actionSecond_ff[10:8], 3'h0);
      end
      axw(adr(0), 8'hEA, 4'hF, 2'h0);
      axw(adr(2), 8'h74, 4'hF, 2'h0);
      repeat (3) @(posedge clk_sys);
      chk(advBits(ctrlFirst_ff), 4'h0);
      chk(ctrlFirst_ff.comfortNoiseScale, 8'h74);
      chk(advBits(ctrlSecond_ff), 4'hF);
      chk(ctrlSecond_ff.comfortNoiseScale, mirror[6]);
      chk(ctrlSecond_ff.noiseRampRate, mirror[7][3:0]);
      // Reset in mid-run must bring back the power-up values
      resetn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk(actionFirst_ff, 32'h0000_0000);
      resetn <= 1'b1;
      axr(adr(0), 32'h0000_00FB, 2'h0);
      axr(adr(6), 32'h0000_0016, 2'h0);
      chk(ctrlFirst_ff.noiseRampRate, 4'h5);
      testDone;
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      nMismatch++;
      testDone;
   end
endmodule
